// ### hw/cnf_params.svh
// Constants of the frame-level node link: field positions, limits, counts.
// Assumes inclusion by bare name from package, interface and modules.
`ifndef CNF_PARAMS_SVH
`define CNF_PARAMS_SVH

`define CNF_ID_W 11
`define CNF_FC_MSB 10
`define CNF_FC_LSB 7
`define CNF_ADDR_MSB 6
`define CNF_ADDR_LSB 0
`define CNF_DLC_W 4
`define CNF_MAX_BYTES 4'h8
`define CNF_DATA_W 64
`define CNF_CHK_W 8
`define CNF_NODE_MIN 7'h01
`define CNF_NODE_MAX 7'h7F
`define CNF_CNT_W 9
`define CNF_WARN_LIM 9'h060
`define CNF_PASSIVE_LIM 9'h07F
`define CNF_BUSOFF_LIM 9'h0FF
`define CNF_TX_ERR_INC 9'h008
`define CNF_RX_ERR_INC 9'h001
`define CNF_CNT_MAX 9'h1FF

`endif

// ### hw/cnf_pkg.sv
// Types and helper functions shared by both node ends and the bench.
// Assumes cnf_params.svh on the include path.
`include "cnf_params.svh"

package cnf_pkg;

    typedef enum logic [1:0] {
        CNF_ERR_ACTIVE,
        CNF_ERR_WARNING,
        CNF_ERR_PASSIVE,
        CNF_BUS_OFF
    } cnf_state_e;

    // Frame check over identifier, format bits, length and payload
    function automatic logic [`CNF_CHK_W-1:0] cnf_chk(
        input logic [`CNF_ID_W-1:0] id,
        input logic ext,
        input logic rtr,
        input logic [`CNF_DLC_W-1:0] dlc,
        input logic [`CNF_DATA_W-1:0] d
    );
        logic [`CNF_CHK_W-1:0] c;
        c = id[7:0] ^ {dlc, ext, id[10:8]} ^ {7'h00, rtr};
        for (int i = 0; i < 8; i++) begin
            c = c ^ d[8*i +: 8];
        end
        return c;
    endfunction

    // Zero the payload bytes beyond the length; byte 0 sits in bits 7:0
    function automatic logic [`CNF_DATA_W-1:0] cnf_mask(
        input logic [`CNF_DATA_W-1:0] d,
        input logic [`CNF_DLC_W-1:0] dlc
    );
        logic [`CNF_DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < dlc) begin
                m[8*i +: 8] = d[8*i +: 8];
            end
        end
        return m;
    endfunction

endpackage

// ### hw/cnf_link_if.sv
// Shared frame bus between the slave node end and the master end.
// Each end offers one frame per cycle; the smaller identifier wins.
`include "cnf_params.svh"

interface cnf_link_if;
    logic dev_req;
    logic [`CNF_ID_W-1:0] dev_id;
    logic dev_ext;
    logic dev_rtr;
    logic [`CNF_DLC_W-1:0] dev_dlc;
    logic [`CNF_DATA_W-1:0] dev_data;
    logic [`CNF_CHK_W-1:0] dev_chk;
    logic dev_ack;
    logic dev_err;
    logic mst_req;
    logic [`CNF_ID_W-1:0] mst_id;
    logic mst_ext;
    logic mst_rtr;
    logic [`CNF_DLC_W-1:0] mst_dlc;
    logic [`CNF_DATA_W-1:0] mst_data;
    logic [`CNF_CHK_W-1:0] mst_chk;
    logic mst_ack;
    logic mst_err;
    logic bus_valid;
    logic bus_from_dev;
    logic [`CNF_ID_W-1:0] bus_id;
    logic bus_ext;
    logic bus_rtr;
    logic [`CNF_DLC_W-1:0] bus_dlc;
    logic [`CNF_DATA_W-1:0] bus_data;
    logic [`CNF_CHK_W-1:0] bus_chk;

    // Arbitration: lower identifier wins
    assign bus_valid = dev_req | mst_req;
    assign bus_from_dev = dev_req & (~mst_req | (dev_id < mst_id));
    assign bus_id = bus_from_dev ? dev_id : mst_id;
    assign bus_ext = bus_from_dev ? dev_ext : mst_ext;
    assign bus_rtr = bus_from_dev ? dev_rtr : mst_rtr;
    assign bus_dlc = bus_from_dev ? dev_dlc : mst_dlc;
    assign bus_data = bus_from_dev ? dev_data : mst_data;
    assign bus_chk = bus_from_dev ? dev_chk : mst_chk;

    modport dev (
        output dev_req, dev_id, dev_ext, dev_rtr, dev_dlc, dev_data, dev_chk,
        output dev_ack, dev_err,
        input mst_ack, mst_err,
        input bus_valid, bus_from_dev, bus_id, bus_ext, bus_rtr, bus_dlc,
        input bus_data, bus_chk
    );
    modport mst (
        output mst_req, mst_id, mst_ext, mst_rtr, mst_dlc, mst_data, mst_chk,
        output mst_ack, mst_err,
        input dev_ack, dev_err,
        input bus_valid, bus_from_dev, bus_id, bus_ext, bus_rtr, bus_dlc,
        input bus_data, bus_chk
    );
endinterface

// ### hw/cnf_pair_buf.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; full refuses writes, empty offers nothing.
module cnf_pair_buf #(
    parameter int W = 79
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_r [2];
    logic wr_r;
    logic rd_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wr_r <= ~wr_r;
            end
            if (pop) begin
                rd_r <= ~rd_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ### hw/cnf_node_dev.sv
// Slave node end: frame transmit with arbitration, filtered receive,
// error counting and error states. Assumes the master end on the link.
// Contract
// R1: Frame is 11-bit identifier plus 0-8 bytes.
// R2: Accept standard frames only, refuse extended.
// R3: Remote request frames never sent nor used.
// R4: Smallest identifier wins arbitration.
// R5: Error counters rise on errors, fall on success.
// R6: Low counts: error active, signal errors.
// R7: Above first limit: warning, still communicating; code warns from 96 on.
// R8: Above second limit: passive, stop signalling.
// R9: Bus off: neither transmit nor receive.
// R10: Detect link errors and signal them.
// R11: Slave node address unique, 1 to 127.
// R12: Numeric payload packed least significant byte first.
// R13: Select received frames by identifier content.
// R14: Data items identified by object index.
// R15: Limits 96, above 127, transmit above 255.
// R16: Identifier is function code over node address.
`include "cnf_params.svh"
module cnf_node_dev
    import cnf_pkg::*;
#(
    parameter int DW = `CNF_DATA_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Link
    cnf_link_if.dev link,
    // Configuration
    input wire logic [6:0] node_id,
    input wire logic [`CNF_ID_W-1:0] acc_id,
    input wire logic [`CNF_ID_W-1:0] acc_mask,
    // Transmit request
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [3:0] tx_fc,
    input wire logic [`CNF_DLC_W-1:0] tx_dlc,
    input wire logic [DW-1:0] tx_data,
    output logic tx_done,
    output logic tx_ok,
    // Received frames
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [`CNF_ID_W-1:0] rx_id,
    output logic [`CNF_DLC_W-1:0] rx_dlc,
    output logic [DW-1:0] rx_data,
    output logic [15:0] rx_index,
    // Status
    output cnf_state_e err_state,
    output logic [`CNF_CNT_W-1:0] tx_err_cnt,
    output logic [`CNF_CNT_W-1:0] rx_err_cnt
);
    localparam int FW = `CNF_ID_W + `CNF_DLC_W + DW;

    cnf_state_e state_r;
    logic [`CNF_CNT_W-1:0] tec_r;
    logic [`CNF_CNT_W-1:0] rec_r;
    logic [`CNF_CNT_W-1:0] tec_nxt;
    logic [`CNF_CNT_W-1:0] rec_nxt;
    logic req_r;
    logic [`CNF_ID_W-1:0] id_r;
    logic [`CNF_DLC_W-1:0] dlc_r;
    logic [DW-1:0] data_r;
    logic done_r;
    logic ok_r;
    logic bus_off;
    logic node_ok;
    logic won;
    logic tx_good;
    logic tx_bad;
    logic rx_slot;
    logic chk_ok;
    logic hit;
    logic take;
    logic rx_bad;
    logic buf_ready;
    logic [FW-1:0] buf_out;
    logic [`CNF_DLC_W-1:0] len;

    ////////////////////////////////////////////////////////////////////
    // Transmit side

    assign bus_off = (state_r == CNF_BUS_OFF);
    assign node_ok = (node_id >= `CNF_NODE_MIN) && (node_id <= `CNF_NODE_MAX); // R11
    assign len = (tx_dlc > `CNF_MAX_BYTES) ? `CNF_MAX_BYTES : tx_dlc; // R1
    assign tx_ready = ~req_r & ~bus_off & node_ok; // R9
    assign won = link.bus_valid & link.bus_from_dev; // R4
    assign tx_good = won & link.mst_ack & ~link.mst_err;
    assign tx_bad = won & ~tx_good;

    assign link.dev_req = req_r & ~bus_off; // R9
    assign link.dev_id = id_r;
    assign link.dev_ext = 1'b0; // R2
    assign link.dev_rtr = 1'b0; // R3
    assign link.dev_dlc = dlc_r;
    assign link.dev_data = data_r;
    assign link.dev_chk = cnf_chk(id_r, 1'b0, 1'b0, dlc_r, data_r);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            id_r <= '0;
            dlc_r <= '0;
            data_r <= '0;
        end else if (tx_valid && tx_ready) begin
            id_r <= {tx_fc, node_id}; // R16
            dlc_r <= len;
            data_r <= cnf_mask(tx_data, len); // R12
        end
    end

    // Failed frames are retried until they succeed or the node goes bus off
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_r <= 1'b0;
            done_r <= 1'b0;
            ok_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (tx_valid && tx_ready) begin
                req_r <= 1'b1;
            end else if (req_r && bus_off) begin
                req_r <= 1'b0;
                done_r <= 1'b1;
                ok_r <= 1'b0;
            end else if (tx_good) begin
                req_r <= 1'b0;
                done_r <= 1'b1;
                ok_r <= 1'b1;
            end
        end
    end

    assign tx_done = done_r;
    assign tx_ok = ok_r;

    ////////////////////////////////////////////////////////////////////
    // Receive side

    assign rx_slot = link.bus_valid & ~link.bus_from_dev & ~bus_off; // R9
    assign chk_ok = (cnf_chk(link.bus_id, link.bus_ext, link.bus_rtr,
                             link.bus_dlc, link.bus_data) == link.bus_chk);
    assign hit = (((link.bus_id ^ acc_id) & acc_mask) == '0); // R13
    assign rx_bad = rx_slot & ~chk_ok; // R10
    assign take = rx_slot & chk_ok & hit & ~link.bus_ext & ~link.bus_rtr // R2 R3
                  & (link.bus_dlc <= `CNF_MAX_BYTES); // R1

    // No acknowledge while the buffer is full; the master reports the frame failed, no retry
    assign link.dev_ack = take & buf_ready;
    assign link.dev_err = rx_bad & ((state_r == CNF_ERR_ACTIVE) // R6
                                    | (state_r == CNF_ERR_WARNING)); // R8

    cnf_pair_buf #(
        .W(FW)
    ) u_rx_buf (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(take),
        .in_ready(buf_ready),
        .in_data({link.bus_id, link.bus_dlc, link.bus_data}),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(buf_out)
    );

    assign rx_id = buf_out[FW-1 -: `CNF_ID_W];
    assign rx_dlc = buf_out[DW +: `CNF_DLC_W];
    assign rx_data = buf_out[DW-1:0];
    assign rx_index = {rx_data[23:16], rx_data[15:8]}; // R14 R12

    ////////////////////////////////////////////////////////////////////
    // Error counters and states

    always_comb begin
        tec_nxt = tec_r;
        rec_nxt = rec_r;
        if (tx_bad) begin
            tec_nxt = (tec_r > `CNF_CNT_MAX - `CNF_TX_ERR_INC) ? `CNF_CNT_MAX
                      : tec_r + `CNF_TX_ERR_INC; // R5
        end else if (tx_good && tec_r != '0) begin
            tec_nxt = tec_r - 9'h001; // R5
        end
        if (rx_bad) begin
            rec_nxt = (rec_r == `CNF_CNT_MAX) ? rec_r : rec_r + `CNF_RX_ERR_INC; // R5
        end else if (link.dev_ack && rec_r != '0) begin
            rec_nxt = rec_r - 9'h001; // R5
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tec_r <= '0;
            rec_r <= '0;
        end else if (!bus_off) begin
            tec_r <= tec_nxt;
            rec_r <= rec_nxt;
        end
    end

    // Bus off holds until reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= CNF_ERR_ACTIVE;
        end else begin
            case (state_r)
                CNF_BUS_OFF: state_r <= CNF_BUS_OFF; // R9
                default: begin
                    if (tec_r > `CNF_BUSOFF_LIM) begin
                        state_r <= CNF_BUS_OFF; // R15
                    end else if (tec_r > `CNF_PASSIVE_LIM || rec_r > `CNF_PASSIVE_LIM) begin
                        state_r <= CNF_ERR_PASSIVE; // R8 R15
                    end else if (tec_r >= `CNF_WARN_LIM || rec_r >= `CNF_WARN_LIM) begin
                        state_r <= CNF_ERR_WARNING; // R7 R15
                    end else begin
                        state_r <= CNF_ERR_ACTIVE; // R6
                    end
                end
            endcase
        end
    end

    assign err_state = state_r;
    assign tx_err_cnt = tec_r;
    assign rx_err_cnt = rec_r;
endmodule

// ### hw/cnf_node_mst.sv
// Master end of the link: sends frames, takes the slave's frames.
// Assumes the slave node end on the same link interface.
`include "cnf_params.svh"
module cnf_node_mst
    import cnf_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Link
    cnf_link_if.mst link,
    // Send command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [3:0] cmd_fc,
    input wire logic [6:0] cmd_node,
    input wire logic cmd_ext,
    input wire logic cmd_corrupt,
    input wire logic [`CNF_DLC_W-1:0] cmd_dlc,
    input wire logic [`CNF_DATA_W-1:0] cmd_data,
    output logic cmd_done,
    output logic cmd_ok,
    // Received frames
    output logic rcv_valid,
    output logic rcv_bad,
    output logic [`CNF_ID_W-1:0] rcv_id,
    output logic [`CNF_DLC_W-1:0] rcv_dlc,
    output logic [`CNF_DATA_W-1:0] rcv_data
);
    logic req_r;
    logic [`CNF_ID_W-1:0] id_r;
    logic ext_r;
    logic bad_r;
    logic [`CNF_DLC_W-1:0] dlc_r;
    logic [`CNF_DATA_W-1:0] data_r;
    logic done_r;
    logic ok_r;
    logic rv_r;
    logic rb_r;
    logic [`CNF_ID_W-1:0] rid_r;
    logic [`CNF_DLC_W-1:0] rdlc_r;
    logic [`CNF_DATA_W-1:0] rdata_r;
    logic [`CNF_DLC_W-1:0] len;
    logic won;
    logic from_dev;
    logic chk_ok;

    assign len = (cmd_dlc > `CNF_MAX_BYTES) ? `CNF_MAX_BYTES : cmd_dlc; // R1
    assign cmd_ready = ~req_r;
    assign won = link.bus_valid & ~link.bus_from_dev; // R4
    assign from_dev = link.bus_valid & link.bus_from_dev;
    assign chk_ok = (cnf_chk(link.bus_id, link.bus_ext, link.bus_rtr,
                             link.bus_dlc, link.bus_data) == link.bus_chk);

    assign link.mst_req = req_r;
    assign link.mst_id = id_r;
    assign link.mst_ext = ext_r;
    assign link.mst_rtr = 1'b0; // R3
    assign link.mst_dlc = dlc_r;
    assign link.mst_data = data_r;
    assign link.mst_chk = cnf_chk(id_r, ext_r, 1'b0, dlc_r, data_r) ^ {7'h00, bad_r};
    assign link.mst_ack = from_dev & chk_ok & ~link.bus_ext & ~link.bus_rtr;
    assign link.mst_err = from_dev & ~chk_ok; // R10

    ////////////////////////////////////////////////////////////////////
    // Sending; a lost arbitration keeps the frame offered

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            id_r <= '0;
            ext_r <= 1'b0;
            bad_r <= 1'b0;
            dlc_r <= '0;
            data_r <= '0;
        end else if (cmd_valid && cmd_ready) begin
            id_r <= {cmd_fc, cmd_node}; // R16 R11
            ext_r <= cmd_ext;
            bad_r <= cmd_corrupt;
            dlc_r <= len;
            data_r <= cnf_mask(cmd_data, len); // R12
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_r <= 1'b0;
            done_r <= 1'b0;
            ok_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (cmd_valid && cmd_ready) begin
                req_r <= 1'b1;
            end else if (won) begin
                req_r <= 1'b0;
                done_r <= 1'b1;
                ok_r <= link.dev_ack & ~link.dev_err;
            end
        end
    end

    assign cmd_done = done_r;
    assign cmd_ok = ok_r;

    ////////////////////////////////////////////////////////////////////
    // Receiving

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rv_r <= 1'b0;
            rb_r <= 1'b0;
            rid_r <= '0;
            rdlc_r <= '0;
            rdata_r <= '0;
        end else begin
            rv_r <= link.mst_ack;
            rb_r <= link.mst_err;
            if (link.mst_ack) begin
                rid_r <= link.bus_id;
                rdlc_r <= link.bus_dlc;
                rdata_r <= link.bus_data;
            end
        end
    end

    assign rcv_valid = rv_r;
    assign rcv_bad = rb_r;
    assign rcv_id = rid_r;
    assign rcv_dlc = rdlc_r;
    assign rcv_data = rdata_r;
endmodule

// ### verif/cnf_link_sva.sv
// Checker on the link between the slave node end and the master end.
// Assumes the bench hands it the link signals, the clock and the reset.
`include "cnf_params.svh"

module cnf_link_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Slave node side
    input wire logic dev_req,
    input wire logic [`CNF_ID_W-1:0] dev_id,
    input wire logic dev_ext,
    input wire logic dev_rtr,
    input wire logic [`CNF_DLC_W-1:0] dev_dlc,
    input wire logic dev_ack,
    input wire logic dev_err,
    // Master side
    input wire logic mst_req,
    input wire logic [`CNF_ID_W-1:0] mst_id,
    input wire logic mst_rtr,
    input wire logic mst_ack,
    // Shared bus
    input wire logic bus_valid,
    input wire logic bus_from_dev,
    input wire logic bus_ext,
    input wire logic bus_rtr,
    input wire logic [`CNF_DLC_W-1:0] bus_dlc
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////
    // Offered frame that nobody took keeps the same identifier and length
    sequence s_dev_unanswered;
        dev_req && !(bus_from_dev && mst_ack);
    endsequence
    sequence s_same_frame;
        !dev_req || ($stable(dev_id) && $stable(dev_dlc));
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    chk_dev_std_only: assert property (
        dev_req |-> !dev_ext && dev_dlc <= `CNF_MAX_BYTES)
        else $error("slave offers an extended or overlong frame");
    chk_no_remote: assert property (
        !(dev_req && dev_rtr) && !(mst_req && mst_rtr))
        else $error("remote request frame offered");
    chk_arb_low_id: assert property (
        dev_req && mst_req |-> bus_from_dev == (dev_id < mst_id))
        else $error("arbitration not won by the smaller identifier");
    chk_hold_frame: assert property (
        s_dev_unanswered |=> s_same_frame)
        else $error("slave frame changed before it was taken");
    chk_ack_legal: assert property (
        dev_ack |-> bus_valid && !bus_from_dev && !bus_ext && !bus_rtr
            && bus_dlc <= `CNF_MAX_BYTES)
        else $error("slave took a frame it must refuse");
    chk_err_only_rx: assert property (
        dev_err |-> bus_valid && !bus_from_dev && !dev_ack)
        else $error("slave error flag outside a master frame");
    chk_addr_nonzero: assert property (
        dev_req |-> dev_id[`CNF_ADDR_MSB:`CNF_ADDR_LSB] != 7'h00)
        else $error("slave frame carries address zero");
    chk_mst_ack_src: assert property (
        mst_ack |-> bus_valid && bus_from_dev)
        else $error("master took a frame the slave did not send");
endmodule

// ### verif/can_node_frame_layer_tb_top.sv
// Bench: slave node end and master end joined over the link.
// Assumes the hw files are compiled first; runs on one clock.
`include "cnf_params.svh"

module can_node_frame_layer_tb_top import cnf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'h0;
    logic reset_n = 1'h0;
    logic [6:0] node_id = 7'h05;
    logic [10:0] acc_id = 11'h000;
    logic [10:0] acc_mask = 11'h000;
    logic tx_valid = 1'h0;
    logic rx_ready = 1'h0;
    logic [3:0] tx_fc = 4'h0;
    logic [3:0] tx_dlc = 4'h0;
    logic [63:0] tx_data = 64'h0;
    logic cmd_valid = 1'h0;
    logic cmd_ext = 1'h0;
    logic cmd_corrupt = 1'h0;
    logic [3:0] cmd_fc = 4'h0;
    logic [6:0] cmd_node = 7'h00;
    logic [3:0] cmd_dlc = 4'h0;
    logic [63:0] cmd_data = 64'h0;
    logic tx_ready, tx_done, tx_ok, rx_valid, cmd_ready, cmd_done, cmd_ok, rcv_valid, rcv_bad;
    logic [10:0] rx_id, rcv_id;
    logic [3:0] rx_dlc, rcv_dlc;
    logic [63:0] rx_data, rcv_data;
    logic [15:0] rx_index;
    logic [8:0] tx_err_cnt, rx_err_cnt;
    cnf_state_e err_state;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    logic err_seen = 1'h0;
    time t_dev, t_mst;

    always #25 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    cnf_link_if cnf_link_if_inst ();
    cnf_node_dev cnf_node_dev_inst (.clock(clock), .reset_n(reset_n),
        .link(cnf_link_if_inst), .node_id(node_id), .acc_id(acc_id), .acc_mask(acc_mask),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_fc(tx_fc), .tx_dlc(tx_dlc),
        .tx_data(tx_data), .tx_done(tx_done), .tx_ok(tx_ok), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
        .rx_index(rx_index), .err_state(err_state), .tx_err_cnt(tx_err_cnt),
        .rx_err_cnt(rx_err_cnt));
    cnf_node_mst cnf_node_mst_inst (.clock(clock), .reset_n(reset_n),
        .link(cnf_link_if_inst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_fc(cmd_fc), .cmd_node(cmd_node), .cmd_ext(cmd_ext), .cmd_corrupt(cmd_corrupt),
        .cmd_dlc(cmd_dlc), .cmd_data(cmd_data), .cmd_done(cmd_done), .cmd_ok(cmd_ok),
        .rcv_valid(rcv_valid), .rcv_bad(rcv_bad), .rcv_id(rcv_id), .rcv_dlc(rcv_dlc),
        .rcv_data(rcv_data));
    cnf_link_sva cnf_link_sva_inst (.clock(clock), .reset_n(reset_n),
        .dev_req(cnf_link_if_inst.dev_req), .dev_id(cnf_link_if_inst.dev_id),
        .dev_ext(cnf_link_if_inst.dev_ext), .dev_rtr(cnf_link_if_inst.dev_rtr),
        .dev_dlc(cnf_link_if_inst.dev_dlc), .dev_ack(cnf_link_if_inst.dev_ack),
        .dev_err(cnf_link_if_inst.dev_err), .mst_req(cnf_link_if_inst.mst_req),
        .mst_id(cnf_link_if_inst.mst_id), .mst_rtr(cnf_link_if_inst.mst_rtr),
        .mst_ack(cnf_link_if_inst.mst_ack), .bus_valid(cnf_link_if_inst.bus_valid),
        .bus_from_dev(cnf_link_if_inst.bus_from_dev), .bus_ext(cnf_link_if_inst.bus_ext),
        .bus_rtr(cnf_link_if_inst.bus_rtr), .bus_dlc(cnf_link_if_inst.bus_dlc));

    // Error flag seen on the wire since last cleared
    always @(negedge clock) begin
        if (cnf_link_if_inst.dev_err === 1'h1) err_seen = 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [63:0] keep(input logic [63:0] d, input int n);
        return (n >= 8) ? d : d & ((64'h1 << (8 * n)) - 64'h1);
    endfunction

    // Slave frame out; returns at the negedge showing tx_done
    task automatic dev_send(input logic [3:0] fc, input logic [3:0] dlc, input logic [63:0] d);
        @(posedge clock);
        tx_valid <= 1'h1;
        tx_fc <= fc;
        tx_dlc <= dlc;
        tx_data <= d;
        do @(negedge clock); while (tx_ready !== 1'h1);
        @(posedge clock);
        tx_valid <= 1'h0;
        do @(negedge clock); while (tx_done !== 1'h1);
        t_dev = $time;
    endtask

    // Master frame out; returns at the negedge showing cmd_done
    task automatic mst_send(input logic [3:0] fc, input logic [6:0] nd, input logic ext,
            input logic bad, input logic [63:0] d);
        @(posedge clock);
        cmd_valid <= 1'h1;
        cmd_fc <= fc;
        cmd_node <= nd;
        cmd_ext <= ext;
        cmd_corrupt <= bad;
        cmd_dlc <= 4'h3;
        cmd_data <= d;
        do @(negedge clock); while (cmd_ready !== 1'h1);
        @(posedge clock);
        cmd_valid <= 1'h0;
        do @(negedge clock); while (cmd_done !== 1'h1);
        t_mst = $time;
    endtask

    task automatic pop(input logic [10:0] id, input logic [63:0] d);
        @(negedge clock);
        check(rx_valid, 64'h1);
        check({rx_id, rx_dlc}, {id, 4'h3});
        check(rx_data, d);
        @(posedge clock) rx_ready <= 1'h1;
        @(posedge clock) rx_ready <= 1'h0;
    endtask

    task automatic corrupt_n(input int n);
        repeat (n) mst_send(4'h4, 7'h05, 1'h0, 1'h1, 64'h0);
        repeat (2) @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] dl [3] = '{4'h6, 4'h0, 4'hF};
        logic [3:0] afc [2] = '{4'h2, 4'h4};
        repeat (2) @(posedge clock);
        reset_n <= 1'h1;
        @(negedge clock);
        check(err_state, CNF_ERR_ACTIVE);
        check({tx_err_cnt, rx_err_cnt, tx_ready, cmd_ready, rx_valid}, 64'h6);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clock) node_id <= (i == 1) ? 7'h7F : 7'h01;
            dev_send(4'h3, dl[i], 64'hAAAA_FF00_1234_5678);
            check({tx_ok, rcv_valid, rcv_bad}, 64'h6);
            check(rcv_id, {4'h3, node_id});
            check(rcv_dlc, (dl[i] > 4'h8) ? 4'h8 : dl[i]);
            check(rcv_data, keep(64'hAAAA_FF00_1234_5678, int'(dl[i])));
        end
        $display("test slave transmit done");
        @(posedge clock) node_id <= 7'h05;
        acc_id <= {4'h4, 7'h05};
        acc_mask <= 11'h7FF;
        mst_send(4'h4, 7'h05, 1'h0, 1'h0, 64'h12_34AB);
        check(cmd_ok, 64'h1);
        check(rx_index, 64'h1234);
        pop({4'h4, 7'h05}, 64'h12_34AB);
        for (int i = 0; i < 3; i++) begin
            mst_send((i == 2) ? 4'h5 : 4'h4, (i == 0) ? 7'h06 : 7'h05, i == 1, 1'h0, 64'h1);
            check({cmd_ok, rx_valid}, 64'h0);
        end
        err_seen = 1'h0;
        corrupt_n(1);
        check({err_seen, rx_err_cnt}, {1'h1, 9'h001});
        mst_send(4'h4, 7'h05, 1'h0, 1'h0, 64'h77);
        check(rx_err_cnt, 64'h0);
        pop({4'h4, 7'h05}, 64'h77);
        $display("test slave receive done");
        @(posedge clock) acc_mask <= 11'h000;
        for (int i = 0; i < 2; i++) begin
            fork
                dev_send(4'h3, 4'h1, 64'h5A);
                mst_send(afc[i], 7'h05, 1'h0, 1'h0, 64'h9);
            join
            check(t_mst < t_dev, i == 0);
            pop({afc[i], 7'h05}, 64'h9);
        end
        $display("test arbitration done");
        for (int i = 0; i < 3; i++) begin
            mst_send(4'h4, 7'h05, 1'h0, 1'h0, 64'(i));
            check(cmd_ok, i < 2);
        end
        pop({4'h4, 7'h05}, 64'h0);
        pop({4'h4, 7'h05}, 64'h1);
        @(negedge clock);
        check(rx_valid, 64'h0);
        $display("test buffer done");
        corrupt_n(95);
        check({rx_err_cnt, err_state}, {9'h05F, CNF_ERR_ACTIVE});
        corrupt_n(1);
        check({rx_err_cnt, err_state}, {9'h060, CNF_ERR_WARNING});
        corrupt_n(31);
        check({rx_err_cnt, err_state}, {9'h07F, CNF_ERR_WARNING});
        corrupt_n(1);
        check({rx_err_cnt, err_state}, {9'h080, CNF_ERR_PASSIVE});
        err_seen = 1'h0;
        corrupt_n(1);
        check({err_seen, rx_err_cnt}, {1'h0, 9'h081});
        mst_send(4'h4, 7'h05, 1'h0, 1'h0, 64'h3);
        check({cmd_ok, rx_err_cnt}, {1'h1, 9'h080});
        pop({4'h4, 7'h05}, 64'h3);
        $display("test error states done");
        give_verdict();
    end
endmodule
